// ==== rtl/swb_pkg.sv ====
// swb_pkg: constants for the subtract-with-borrow execution block
// assumes a core that feeds one instruction word per four-phase cycle
package swb_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 12;
  localparam int          BANK_W        = 4;
  localparam int          INSTR_W       = 16;
  // upper six bits of the opcode: 0101 01
  localparam logic [5:0]  OPC_SWB       = 6'h15;
  localparam int          OPC_HI        = 15;
  localparam int          OPC_LO        = 10;
  localparam int          DEST_BIT      = 9;
  localparam int          BANK_BIT      = 8;
  // highest register address using indexed literal offset
  localparam logic [7:0]  IDX_LIMIT     = 8'h5F;
  // access bank: offsets below 0x60 map to bank 0, the rest to bank 15
  localparam logic [7:0]  ACC_SPLIT     = 8'h60;
  localparam logic [3:0]  BANK_HI       = 4'hF;
  localparam logic [3:0]  BANK_LO       = 4'h0;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic [11:0] ADDR_RESET    = 12'h000;
  // status flag positions in the flag vector
  localparam int          FLG_BORROW_N  = 0;
  localparam int          FLG_HALF      = 1;
  localparam int          FLG_ZERO      = 2;
  localparam int          FLG_OVF       = 3;
  localparam int          FLG_MSB       = 4;
  localparam logic [4:0]  FLAGS_RESET   = 5'h00;
  typedef enum logic [1:0] {
    SWB_Q1 = 2'b00,
    SWB_Q2 = 2'b01,
    SWB_Q3 = 2'b10,
    SWB_Q4 = 2'b11
  } swb_phase_type;
endpackage : swb_pkg

// ==== rtl/swb_core.sv ====
// swb_core: executes the subtract-with-borrow-from-accumulator instruction
// assumes i_instr and i_fsr_base are held stable over a whole cycle and
// the data memory answers a read within the same phase in which the address is shown
//
// What this block does
// - difference is acc minus reg minus borrow
// - destination bit 0 writes the accumulator
// - destination bit 1 writes the register back
// - bank bit 0 selects the access bank
// - bank bit 1 prefixes the bank pointer
// - extended set, low addresses use index offset
// - five arithmetic flags are updated
// - decode upper byte pattern 0101 01da
module swb_core
  import swb_pkg::*;
(
  // clock and reset
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_sys_rst,
  // instruction stream
  input  wire logic [swb_pkg::INSTR_W-1:0] i_instr,
  input  wire logic                      i_ext_set_en,
  input  wire logic [swb_pkg::BANK_W-1:0]  i_bank_pointer,
  input  wire logic [swb_pkg::ADDR_W-1:0]  i_fsr_base,
  // data memory
  output logic [swb_pkg::ADDR_W-1:0]     o_mem_addr,
  output logic                           o_mem_rd,
  output logic                           o_mem_wr,
  output logic [swb_pkg::DATA_W-1:0]     o_mem_wdata,
  input  wire logic [swb_pkg::DATA_W-1:0]  i_mem_rdata,
  // architectural state
  output logic [swb_pkg::DATA_W-1:0]     o_acc,
  output logic                           o_msb_flag,
  output logic                           o_signed_range_exceeded_flag,
  output logic                           o_borrow_inverse_flag,
  output logic                           o_half_carry_flag,
  output logic                           o_all_bits_clear_flag,
  output logic                           o_exec_done
);
  import swb_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  swb_phase_type             phase_q;
  logic                      hit_q;
  logic                      dest_q;
  logic [ADDR_W-1:0]         addr_q;
  logic [DATA_W-1:0]         opnd_q;
  logic [DATA_W-1:0]         res_q;
  logic [4:0]                flags_q;
  logic [4:0]                flags_d;
  logic [DATA_W-1:0]         acc_q;
  logic                      done_q;
  logic                      hit_d;
  logic [ADDR_W-1:0]         addr_d;
  logic [DATA_W:0]           diff_full;
  logic [4:0]                half_full;
  logic [DATA_W-1:0]         diff;

  // every check below runs on the core clock and sleeps in reset
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------------------------------
  // decode and address
  // ----------------------------------------------------------------
  // opcode match
  assign hit_d = (i_instr[OPC_HI:OPC_LO] == OPC_SWB);

  // address forming; the indexed case wraps within the data space
  always_comb begin
    addr_d = ADDR_RESET;
    if (i_ext_set_en && !i_instr[BANK_BIT]
        && (i_instr[7:0] <= IDX_LIMIT)) begin
      addr_d = i_fsr_base + {{(ADDR_W-8){1'b0}}, i_instr[7:0]};
    end else if (!i_instr[BANK_BIT]) begin
      addr_d = {(i_instr[7:0] < ACC_SPLIT) ? BANK_LO : BANK_HI,
                i_instr[7:0]};
    end else begin
      addr_d = {i_bank_pointer, i_instr[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // acc - reg - not carry
  assign diff_full = {1'b0, acc_q} - {1'b0, opnd_q}
                     - {{DATA_W{1'b0}}, ~flags_q[FLG_BORROW_N]};
  assign half_full = {1'b0, acc_q[3:0]} - {1'b0, opnd_q[3:0]}
                     - {4'h0, ~flags_q[FLG_BORROW_N]};
  assign diff      = diff_full[DATA_W-1:0];

  always_comb begin
    flags_d = flags_q;
    flags_d[FLG_BORROW_N] = ~diff_full[DATA_W];
    flags_d[FLG_HALF]     = ~half_full[4];
    flags_d[FLG_ZERO]     = (diff == ACC_RESET);
    flags_d[FLG_MSB]      = diff[DATA_W-1];
    // overflow: operand signs differ and result sign follows subtrahend
    flags_d[FLG_OVF]      = (acc_q[DATA_W-1] != opnd_q[DATA_W-1])
                            && (diff[DATA_W-1] != acc_q[DATA_W-1]);
  end

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  // four phases per cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      phase_q <= SWB_Q1;
    end else begin
      case (phase_q)
        SWB_Q1:  phase_q <= SWB_Q2;
        SWB_Q2:  phase_q <= SWB_Q3;
        SWB_Q3:  phase_q <= SWB_Q4;
        default: phase_q <= SWB_Q1;
      endcase
    end
  end

  phase_wrap_a: assert property (phase_q == SWB_Q4
    |=> phase_q == SWB_Q1)
    else $error("phase did not wrap");

  // decode latch at the first phase
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      hit_q  <= 1'b0;
      dest_q <= 1'b0;
      addr_q <= ADDR_RESET;
    end else if (phase_q == SWB_Q1) begin
      hit_q  <= hit_d;
      dest_q <= i_instr[DEST_BIT];
      addr_q <= addr_d;
    end
  end

  bank_addr_a: assert property ((phase_q == SWB_Q1 && hit_d
    && i_instr[BANK_BIT]) |=> addr_q == {$past(i_bank_pointer),
    $past(i_instr[7:0])})
    else $error("banked address wrong");

  // operand capture at the read phase
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      opnd_q <= ACC_RESET;
    end else if (phase_q == SWB_Q2 && hit_q) begin
      opnd_q <= i_mem_rdata;
    end
  end

  // compute phase: result and flags
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      res_q   <= ACC_RESET;
      flags_q <= FLAGS_RESET;
    end else if (phase_q == SWB_Q3 && hit_q) begin
      res_q   <= diff;
      flags_q <= flags_d;
    end
  end

  // difference by add-inverse identity
  // a - b - not c equals a + not b + c, so this is a second formula
  diff_value_a: assert property ((phase_q == SWB_Q3 && hit_q)
    |=> res_q == $past(acc_q + ~opnd_q
                       + {{(DATA_W-1){1'b0}}, flags_q[FLG_BORROW_N]}))
    else $error("difference wrong");
  zero_flag_a: assert property ((phase_q == SWB_Q3 && hit_q)
    |=> o_all_bits_clear_flag == (res_q == 8'h00))
    else $error("zero flag wrong");
  msb_flag_a: assert property ((phase_q == SWB_Q3 && hit_q)
    |=> o_msb_flag == res_q[7])
    else $error("msb flag wrong");

  // write phase: accumulator update
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      acc_q <= ACC_RESET;
    end else if (phase_q == SWB_Q4 && hit_q && !dest_q) begin
      acc_q <= res_q;
    end
  end

  acc_hold_a: assert property (o_mem_wr |=> $stable(acc_q))
    else $error("acc changed on register write");
  acc_write_a: assert property ((phase_q == SWB_Q4
    && hit_q && !dest_q) |=> acc_q == $past(res_q))
    else $error("acc not written");

  // completion pulse, one per executed instruction
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (phase_q == SWB_Q4) && hit_q;
    end
  end

  done_cycle_a: assert property (o_exec_done
    |-> $past(phase_q) == SWB_Q4)
    else $error("done outside write phase");

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_mem_addr  = addr_q;
  assign o_mem_rd    = (phase_q == SWB_Q2) && hit_q;
  assign o_mem_wr    = (phase_q == SWB_Q4) && hit_q && dest_q;
  assign o_mem_wdata = res_q;
  assign o_acc       = acc_q;
  assign o_msb_flag                   = flags_q[FLG_MSB];
  assign o_signed_range_exceeded_flag = flags_q[FLG_OVF];
  assign o_borrow_inverse_flag        = flags_q[FLG_BORROW_N];
  assign o_half_carry_flag            = flags_q[FLG_HALF];
  assign o_all_bits_clear_flag        = flags_q[FLG_ZERO];
  assign o_exec_done                  = done_q;

  read_once_a: assert property (o_mem_rd |=> !o_mem_rd [*3])
    else $error("extra operand read");

  // ----------------------------------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------------------------------
  to_acc_c:   cover property (phase_q == SWB_Q4 && hit_q && !dest_q);
  to_reg_c:   cover property (o_mem_wr);
  borrow_c:   cover property (done_q && !o_borrow_inverse_flag);
  zero_res_c: cover property (done_q && o_all_bits_clear_flag);
endmodule // swb_core

// ==== bench/tb_top.sv ====
// tb_top: self-checking bench for swb_core
// assumes one instruction per four clocks, back to back
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import swb_pkg::*;
  // ----------------------------------------
  // signals and case table
  // ----------------------------------------
  typedef struct packed {
    logic        d;
    logic        a;
    logic        ext;
    logic [3:0]  bank;
    logic [7:0]  f;
    logic [7:0]  rd;
    logic [11:0] addr;
  } swb_row_type;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [15:0]        instr = 16'h0000;
  logic               ext = 1'b0;
  logic [3:0]         bank = 4'h0;
  logic [11:0]        fsr = 12'h300;
  logic [7:0]         rdata = 8'h00;
  logic [11:0]        addr;
  logic [7:0]         wdata;
  logic [7:0]         acc;
  logic               rd;
  logic               wr;
  logic               done;
  logic [4:0]         flg;
  logic [7:0]         acc_m = 8'h00;
  logic               c_m = 1'b0;
  int                 num_errors = 0;
  int                 total_checks = 0;
  swb_row_type        r;
  // index base 0x300, bank-0 split at 0x60, wraps 12 bits
  localparam swb_row_type ROWS [8] = '{
    '{1'b0, 1'b0, 1'b0, 4'h3, 8'h10, 8'hFA, 12'h010},
    '{1'b0, 1'b0, 1'b0, 4'h3, 8'h80, 8'h01, 12'hF80},
    '{1'b1, 1'b1, 1'b0, 4'h5, 8'h22, 8'h7F, 12'h522},
    '{1'b1, 1'b1, 1'b1, 4'h2, 8'h10, 8'h80, 12'h210},
    '{1'b0, 1'b0, 1'b1, 4'h7, 8'h5F, 8'h03, 12'h35F},
    '{1'b1, 1'b0, 1'b1, 4'h7, 8'h60, 8'h00, 12'hF60},
    '{1'b0, 1'b0, 1'b0, 4'h1, 8'h5F, 8'h88, 12'h05F},
    '{1'b0, 1'b1, 1'b0, 4'hF, 8'hFF, 8'h0F, 12'hFFF}};

  swb_core i_swb_core (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_instr(instr),
    .i_ext_set_en(ext), .i_bank_pointer(bank), .i_fsr_base(fsr),
    .o_mem_addr(addr), .o_mem_rd(rd), .o_mem_wr(wr),
    .o_mem_wdata(wdata), .i_mem_rdata(rdata), .o_acc(acc),
    .o_msb_flag(flg[4]), .o_signed_range_exceeded_flag(flg[3]),
    .o_borrow_inverse_flag(flg[2]), .o_half_carry_flag(flg[1]),
    .o_all_bits_clear_flag(flg[0]), .o_exec_done(done));

  // ----------------------------------------
  // clock, compare and closing tasks
  // ----------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic check(input string nm, input logic [11:0] e, g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one slot; non-matching word m=0 must give no strobes
  task automatic exec(input swb_row_type w, input logic m);
    logic [8:0] df;
    logic [4:0] hf;
    logic [4:0] ef;
    instr = {(m ? OPC_SWB : 6'h14), w.d, w.a, w.f};
    ext = w.ext;
    bank = w.bank;
    @(posedge clk);
    #1;
    if (m) check("addr", w.addr, addr);
    check("rd", {11'h000, m}, {11'h000, rd});
    rdata = w.rd;
    df = {1'b0, acc_m} - {1'b0, w.rd} - {8'h00, ~c_m};
    hf = {1'b0, acc_m[3:0]} - {1'b0, w.rd[3:0]} - {4'h0, ~c_m};
    repeat (2) @(posedge clk);
    #1;
    rdata = ~w.rd; // read window closed, show a changed value
    check("wr", {11'h000, m & w.d}, {11'h000, wr});
    if (m && w.d) check("wdata", {4'h0, df[7:0]}, {4'h0, wdata});
    ef = {df[7], (acc_m[7] ^ w.rd[7]) & (df[7] ^ acc_m[7]), ~df[8],
          ~hf[4], df[7:0] == 8'h00};
    if (m) check("flags", {7'h00, ef}, {7'h00, flg});
    @(posedge clk);
    #1;
    if (m && !w.d) acc_m = df[7:0];
    if (m) c_m = ~df[8];
    check("acc", {4'h0, acc_m}, {4'h0, acc});
    check("done", {11'h000, m}, {11'h000, done});
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    check("rst acc", 12'h000, {4'h0, acc});
    for (int i = 0; i < 8; i++) exec(ROWS[i], 1'b1);
    exec(ROWS[2], 1'b0);
    // zero result picked from the model, back to back
    r = ROWS[4];
    r.rd = acc_m - {7'h00, ~c_m};
    exec(r, 1'b1);
    // index base near the top wraps inside the data space
    fsr = 12'hFF0;
    r = ROWS[4];
    r.f = 8'h20;
    r.addr = 12'h010;
    exec(r, 1'b1);
    fsr = 12'h300;
    // mid-run reset clears acc and flags
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check("rst flags", 12'h000, {7'h00, flg});
    acc_m = 8'h00;
    c_m = 1'b0;
    exec(ROWS[0], 1'b1);
    complete_run();
  end
  // run needs about 70 clocks; allow about twenty-eight times that
  initial begin
    #80000;
    num_errors++;
    complete_run();
  end
endmodule // tb_top
